// >>> hw/xbmux_params.svh
// Named constants for the X-bus pin multiplexer
`ifndef XBMUX_PARAMS_SVH
`define XBMUX_PARAMS_SVH

// Clock period and ISA reset pulse time
`define XBMUX_CLK_PERIOD_NS 10
`define XBMUX_ISA_RST_TIME_NS 1000000

// Strap vector bit positions and width
`define XBMUX_STRAP_MODE 0
`define XBMUX_STRAP_SECURE 1
`define XBMUX_STRAP_BUFEN 2
`define XBMUX_STRAP_W 3
`define XBMUX_STRAP_RESET 3'h0

// Break event enables span four configuration bytes
`define XBMUX_BREAK_W 32
`define XBMUX_ADDR_W 16

// I/O range served by the second select in embedded mode
`define XBMUX_IO800_BASE 16'h0800
`define XBMUX_IO800_LAST 16'h08FF

// Reset levels
`define XBMUX_OFF 1'h0
`define XBMUX_ON 1'h1

`endif

// >>> hw/xbmux_pkg.sv
// Types shared by the X-bus pin multiplexer
`default_nettype none
package xbmux_pkg;
	typedef enum logic [0:0] {
		MODE_PC = 1'h0,
		MODE_EMB = 1'h1
	} xbmux_mode_t;

	typedef enum logic [1:0] {
		DEV_IDLE = 2'h0,
		DEV_RTC_ADDR = 2'h1,
		DEV_RTC_DATA = 2'h2,
		DEV_ROM_KBC = 2'h3
	} xbmux_dev_t;
endpackage
`default_nettype wire

// >>> hw/xbmux_pulse_timer.sv
// Retriggerable fixed-length pulse timer
`default_nettype none
module xbmux_pulse_timer
#(
	parameter int unsigned CYCLES = 100000,
	parameter int unsigned CW = $clog2(CYCLES + 1)
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic start,
	output var logic active
);
	logic [CW-1:0] countQ;
	int unsigned runLenQ;

	// A new start reloads the full length rather than extending the tail
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			countQ <= '0;
			active <= 1'h0;
		end
		else if (start)
		begin
			countQ <= CW'(CYCLES);
			active <= 1'h1;
		end
		else if (countQ > CW'(1))
		begin
			countQ <= countQ - CW'(1);
			active <= 1'h1;
		end
		else
		begin
			countQ <= '0;
			active <= 1'h0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst || start || !active)
			runLenQ <= 0;
		else
			runLenQ <= runLenQ + 1;
	end

	a_timer_start: assert property (@(posedge ref_clk) disable iff (rst)
		start |=> active)
		else $error("pulse did not start");
	a_timer_length: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(active) |-> ($past(runLenQ) + 1 == CYCLES))
		else $error("pulse length wrong");
endmodule
`default_nettype wire

// >>> hw/xbmux_strap_latch.sv
// Strap capture on the first clock after reset release
`default_nettype none
module xbmux_strap_latch
#(
	parameter int unsigned W = 3,
	parameter logic [W-1:0] RESET_VAL = '0
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [W-1:0] strapIn,
	output var logic [W-1:0] sampled,
	output var logic valid
);
	// Pins are undriven until valid rises, so the sample sees the strap resistors only
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			sampled <= RESET_VAL;
			valid <= 1'h0;
		end
		else if (!valid)
		begin
			sampled <= strapIn;
			valid <= 1'h1;
		end
	end

	a_strap_hold: assert property (@(posedge ref_clk) disable iff (rst)
		valid |=> valid && $stable(sampled))
		else $error("strap value changed after capture");
endmodule
`default_nettype wire

// >>> hw/xbmux_top.sv
// Mode-dependent X-bus pins, ISA reset pulse and X-bus buffer control
// Notes on behaviour
// [R1] Strap after power-up selects operating mode
// [R2] Embedded mode: reset pulse on any one of three events
// [R3] ISA reset is inverted PCI reset
// [R4] PC mode: activity output on break event
// [R5] Break events enabled from four config bytes
// [R6] Read control low moves X-bus data
// [R7] Secure strap sampled, shown as port bit in embedded mode only
// [R8] Buffer enable asserted on X-bus decode
// [R9] Low buffer strap enters test mode
// [R10] Embedded mode: first select is boot ROM
// [R11] Embedded mode: second select for 800h-8FFh
// [R12] PC mode: selects carry encoded device
// [R13] Read control high when not reading
`include "xbmux_params.svh"
`default_nettype none
module xbmux_top
#(
	parameter int unsigned RST_PULSE_CYCLES = `XBMUX_ISA_RST_TIME_NS / `XBMUX_CLK_PERIOD_NS,
	parameter int unsigned BREAK_W = `XBMUX_BREAK_W,
	parameter int unsigned ADDR_W = `XBMUX_ADDR_W
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic modeStrapIn,
	input wire logic power_good_in,
	input wire logic pciResetN,
	input wire logic hotResetBit,
	input wire logic resetDriveBit,
	input wire logic [BREAK_W-1:0] breakEnable,
	input wire logic [BREAK_W-1:0] breakEvents,
	input wire logic cycleActive,
	input wire logic cycleIsIo,
	input wire logic cycleIsRead,
	input wire logic [ADDR_W-1:0] cycleAddr,
	input wire logic romRangeHit,
	input wire logic rtcAddrHit,
	input wire logic rtcDataHit,
	input wire logic romKbcHit,
	input wire logic secure_strap_in,
	output var logic xbus_read_n,
	output var logic xbusReadOe,
	input wire logic xbusBufStrapIn,
	output var logic xbus_buf_en_n,
	output var logic xbusBufEnOe,
	output var logic resetActivityPin,
	output var logic isa_bus_reset_out,
	output var logic pm_activity_n,
	output var logic xbus_sel_lo,
	output var logic xbus_sel_hi,
	output var logic boot_rom_sel,
	output var logic io_800_range_sel,
	output var xbmux_pkg::xbmux_dev_t xbus_dev_code,
	output var logic romDefaultTiming,
	output var logic port92SecureBit,
	output var logic testMode,
	output var xbmux_pkg::xbmux_mode_t activeMode
);
	import xbmux_pkg::*;

	wire logic [`XBMUX_STRAP_W-1:0] strapVec;
	wire logic [`XBMUX_STRAP_W-1:0] strapSampled;
	wire logic strapsValid;
	wire logic embMode;
	wire logic pgRise;
	wire logic hotRise;
	wire logic drvRise;
	wire logic pulseStart;
	wire logic pulseActive;
	wire logic isaRstD;
	wire logic pmActND;
	wire logic io800Hit;
	wire logic romHit;
	wire xbmux_dev_t pcCode;
	wire logic decoded;
	wire logic selLoD;
	wire logic selHiD;
	wire logic readND;
	logic pgPrevQ;
	logic hotPrevQ;
	logic drvPrevQ;

	assign strapVec[`XBMUX_STRAP_MODE] = modeStrapIn;
	assign strapVec[`XBMUX_STRAP_SECURE] = secure_strap_in;
	assign strapVec[`XBMUX_STRAP_BUFEN] = xbusBufStrapIn;

	// [R1] Mode strap capture
	// The two-way pins stay undriven while their straps are sampled
	xbmux_strap_latch #(
		.W(`XBMUX_STRAP_W),
		.RESET_VAL(`XBMUX_STRAP_RESET)
	) u_straps (
		.ref_clk(ref_clk),
		.rst(rst),
		.strapIn(strapVec),
		.sampled(strapSampled),
		.valid(strapsValid)
	);

	// [R1] Pin functions follow the mode
	assign embMode = strapsValid &&
		(xbmux_mode_t'(strapSampled[`XBMUX_STRAP_MODE]) == MODE_EMB);

	// [R2] Edge detection of the three triggers
	// Edges are held off until the straps are known, so a high level at release counts
	assign pgRise = power_good_in && !pgPrevQ;
	assign hotRise = hotResetBit && !hotPrevQ;
	assign drvRise = resetDriveBit && !drvPrevQ;
	assign pulseStart = embMode && (pgRise || hotRise || drvRise);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pgPrevQ <= `XBMUX_OFF;
			hotPrevQ <= `XBMUX_OFF;
			drvPrevQ <= `XBMUX_OFF;
		end
		else
		begin
			pgPrevQ <= strapsValid ? power_good_in : `XBMUX_OFF;
			hotPrevQ <= strapsValid ? hotResetBit : `XBMUX_OFF;
			drvPrevQ <= strapsValid ? resetDriveBit : `XBMUX_OFF;
		end
	end

	// [R2] One millisecond reset pulse
	xbmux_pulse_timer #(
		.CYCLES(RST_PULSE_CYCLES)
	) u_rst_pulse (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(pulseStart),
		.active(pulseActive)
	);

	// [R3] PCI reset forces ISA reset
	assign isaRstD = !pciResetN || pulseActive;

	// [R4] [R5] Enabled break events drive activity low
	assign pmActND = !(|(breakEvents & breakEnable));

	// [R11] I/O window decode
	assign io800Hit = cycleActive && cycleIsIo &&
		(cycleAddr >= ADDR_W'(`XBMUX_IO800_BASE)) && (cycleAddr <= ADDR_W'(`XBMUX_IO800_LAST));
	// [R10] Boot ROM memory decode
	assign romHit = cycleActive && !cycleIsIo && romRangeHit;

	// [R12] Device encoding, RTC address latch takes priority
	assign pcCode = !cycleActive ? DEV_IDLE :
		rtcAddrHit ? DEV_RTC_ADDR :
		rtcDataHit ? DEV_RTC_DATA :
		romKbcHit ? DEV_ROM_KBC : DEV_IDLE;

	// [R10] [R11] [R12] Select pin muxing by mode
	assign selLoD = embMode ? romHit : pcCode[0];
	assign selHiD = embMode ? io800Hit : pcCode[1];

	// [R8] Any X-bus device decoded
	assign decoded = strapsValid && (embMode ? (romHit || io800Hit) : (pcCode != DEV_IDLE));

	// [R6] [R13] Read control direction
	assign readND = !(decoded && cycleIsRead);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			isa_bus_reset_out <= `XBMUX_ON;
			pm_activity_n <= `XBMUX_ON;
			resetActivityPin <= `XBMUX_ON;
		end
		else
		begin
			isa_bus_reset_out <= isaRstD;
			pm_activity_n <= pmActND;
			resetActivityPin <= embMode ? isaRstD : pmActND;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			xbus_sel_lo <= `XBMUX_OFF;
			xbus_sel_hi <= `XBMUX_OFF;
			boot_rom_sel <= `XBMUX_OFF;
			io_800_range_sel <= `XBMUX_OFF;
			xbus_dev_code <= DEV_IDLE;
			romDefaultTiming <= `XBMUX_OFF;
		end
		else
		begin
			xbus_sel_lo <= strapsValid && selLoD;
			xbus_sel_hi <= strapsValid && selHiD;
			boot_rom_sel <= embMode && romHit;
			io_800_range_sel <= embMode && io800Hit;
			xbus_dev_code <= (strapsValid && !embMode) ? pcCode : DEV_IDLE;
			romDefaultTiming <= embMode && romHit;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			xbus_read_n <= `XBMUX_ON;
			xbusReadOe <= `XBMUX_OFF;
			xbus_buf_en_n <= `XBMUX_ON;
			xbusBufEnOe <= `XBMUX_OFF;
		end
		else
		begin
			xbus_read_n <= readND;
			xbusReadOe <= strapsValid;
			xbus_buf_en_n <= !decoded;
			xbusBufEnOe <= strapsValid;
		end
	end

	// [R7] [R9] Strap results shown to software and test logic
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			port92SecureBit <= `XBMUX_OFF;
			testMode <= `XBMUX_OFF;
			activeMode <= MODE_PC;
		end
		else
		begin
			port92SecureBit <= embMode && strapSampled[`XBMUX_STRAP_SECURE];
			testMode <= strapsValid && !strapSampled[`XBMUX_STRAP_BUFEN];
			activeMode <= embMode ? MODE_EMB : MODE_PC;
		end
	end

	// Checks look at least one edge ahead because every output is registered
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	a_mode_stable: assert property ( // [R1]
		strapsValid ##1 strapsValid |=> $stable(activeMode))
		else $error("mode changed after strap capture");
	a_pulse_on_trig: assert property ( // [R2]
		pulseStart |=> ##1 isa_bus_reset_out && resetActivityPin)
		else $error("reset pulse missing after trigger");
	a_pci_reset: assert property ( // [R3]
		!pciResetN |=> isa_bus_reset_out)
		else $error("ISA reset not following PCI reset");
	a_pm_activity: assert property ( // [R4]
		(|(breakEvents & breakEnable)) && strapsValid && !embMode |=>
			!pm_activity_n && !resetActivityPin)
		else $error("activity output not asserted");
	a_pm_idle: assert property ( // [R5]
		!(|(breakEvents & breakEnable)) |=> pm_activity_n)
		else $error("activity asserted without enabled event");
	a_read_low: assert property ( // [R6]
		decoded && cycleIsRead |=> !xbus_read_n && xbusReadOe)
		else $error("read control not low on X-bus read");
	a_secure_bit: assert property ( // [R7]
		strapsValid |=> port92SecureBit == (embMode && strapSampled[`XBMUX_STRAP_SECURE]))
		else $error("secure bit does not match strap");
	a_buf_enable: assert property ( // [R8]
		decoded |=> !xbus_buf_en_n ##1 (xbus_buf_en_n == !$past(decoded)))
		else $error("buffer enable does not track decode");
	a_test_mode: assert property ( // [R9]
		strapsValid |=> testMode == !strapSampled[`XBMUX_STRAP_BUFEN])
		else $error("test mode does not match strap");
	a_rom_select: assert property ( // [R10]
		embMode && romHit |=> xbus_sel_lo && boot_rom_sel && romDefaultTiming)
		else $error("boot ROM select missing");
	a_io_window: assert property ( // [R11]
		embMode && cycleActive && cycleIsIo && cycleAddr[ADDR_W-1:8] == 8'h08 |=> xbus_sel_hi)
		else $error("I/O window select missing");
	a_dev_code: assert property ( // [R12]
		strapsValid && !embMode |=> {xbus_sel_hi, xbus_sel_lo} == $past(pcCode))
		else $error("encoded device select wrong");
	a_read_high: assert property ( // [R13]
		!(decoded && cycleIsRead) |=> xbus_read_n)
		else $error("read control low while not reading");
	a_oe_release: assert property ( // [R7]
		!strapsValid |=> !xbusReadOe && !xbusBufEnOe)
		else $error("shared pins driven during strap sampling");
	a_pc_no_emb: assert property ( // [R1]
		strapsValid && !embMode |=> !boot_rom_sel && !io_800_range_sel && !romDefaultTiming)
		else $error("embedded select active in PC mode");
	a_emb_code_idle: assert property ( // [R12]
		embMode |=> xbus_dev_code == DEV_IDLE)
		else $error("device code driven in embedded mode");
	a_emb_pin_reset: assert property ( // [R1]
		embMode |=> resetActivityPin == isa_bus_reset_out)
		else $error("shared pin not carrying ISA reset");

	c_emb_pulse: cover property (pulseStart ##1 pulseActive);
	c_io_window: cover property (embMode ##1 io_800_range_sel);
	c_pc_rom_kbc: cover property (strapsValid && !embMode ##1 xbus_dev_code == DEV_ROM_KBC);
	c_test_mode: cover property (testMode);
	c_pm_activity: cover property (!embMode && strapsValid ##1 !pm_activity_n);
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the X-bus pin multiplexer
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import xbmux_pkg::*;
	// Short pulse keeps the run brief; the pulse end expectations derive from it, the pulse start ones are fixed at 1 and 2 cycles
	localparam int unsigned PULSE = 8;
	typedef struct {string nm; logic [20:0] m; logic [20:0] e; int due;} xbmux_note_t;
	logic ref_clk, rst, modeStrapIn, power_good_in, pciResetN, hotResetBit, resetDriveBit;
	logic [31:0] breakEnable, breakEvents;
	logic cycleActive, cycleIsIo, cycleIsRead, romRangeHit, rtcAddrHit, rtcDataHit, romKbcHit;
	logic [15:0] cycleAddr;
	logic secure_strap_in, xbus_read_n, xbusReadOe, xbusBufStrapIn, xbus_buf_en_n, xbusBufEnOe;
	logic resetActivityPin, isa_bus_reset_out, pm_activity_n, xbus_sel_lo, xbus_sel_hi;
	logic boot_rom_sel, io_800_range_sel, romDefaultTiming, port92SecureBit, testMode;
	logic secureLevel, bufStrapLow;
	logic [3:0] devSelect;
	xbmux_dev_t xbus_dev_code;
	xbmux_mode_t activeMode;
	wire logic [20:0] obs;
	int fail_count, checks, posCount;
	xbmux_note_t notes[$];
	assign obs = {devSelect, xbusBufEnOe, xbusReadOe, activeMode, testMode, port92SecureBit,
		romDefaultTiming, xbus_dev_code, io_800_range_sel, boot_rom_sel, xbus_sel_hi, xbus_sel_lo,
		pm_activity_n, isa_bus_reset_out, resetActivityPin, xbus_buf_en_n, xbus_read_n};
	xbmux_top #(.RST_PULSE_CYCLES(PULSE)) u_xbmux_top (.ref_clk, .rst, .modeStrapIn,
		.power_good_in, .pciResetN, .hotResetBit, .resetDriveBit, .breakEnable, .breakEvents,
		.cycleActive, .cycleIsIo, .cycleIsRead, .cycleAddr, .romRangeHit, .rtcAddrHit,
		.rtcDataHit, .romKbcHit, .secure_strap_in, .xbus_read_n, .xbusReadOe, .xbusBufStrapIn,
		.xbus_buf_en_n, .xbusBufEnOe, .resetActivityPin, .isa_bus_reset_out, .pm_activity_n,
		.xbus_sel_lo, .xbus_sel_hi, .boot_rom_sel, .io_800_range_sel, .xbus_dev_code,
		.romDefaultTiming, .port92SecureBit, .testMode, .activeMode);
	xbmux_xbus_model u_xbmux_xbus_model (.xbus_read_n, .xbusReadOe, .xbus_buf_en_n,
		.xbusBufEnOe, .xbus_sel_lo, .xbus_sel_hi, .secureLevel, .bufStrapLow,
		.securePin(secure_strap_in), .bufPin(xbusBufStrapIn), .devSelect);
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic tally_and_finish();
		if (fail_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Notes stay sorted by due cycle so the oldest due one is always in front
	task automatic file_note(input xbmux_note_t n);
		int i;
		i = notes.size();
		while (i > 0 && notes[i - 1].due > n.due)
			i--;
		notes.insert(i, n);
	endtask
	task automatic note(input string nm, input logic [14:0] m, input logic [14:0] e, input int lat);
		xbmux_note_t n;
		n = '{nm, {6'h00, m}, {6'h00, e & m}, posCount + lat};
		file_note(n);
	endtask
	// Upper watch bits are {devSelect, xbusBufEnOe, xbusReadOe}
	task automatic note_hi(input string nm, input logic [5:0] m, input logic [5:0] e,
		input int lat);
		xbmux_note_t n;
		n = '{nm, {m, 15'h0000}, {e & m, 15'h0000}, posCount + lat};
		file_note(n);
	endtask
	always @(posedge ref_clk)
	begin
		posCount = posCount + 1;
		#2;
		while (notes.size() > 0 && notes[0].due <= posCount)
		begin
			checks = checks + 1;
			if ((obs & notes[0].m) !== notes[0].e)
			begin
				fail_count = fail_count + 1;
				$display("FAIL %s expected %h seen %h", notes[0].nm, notes[0].e, obs & notes[0].m);
			end
			void'(notes.pop_front());
		end
	end
	always @(posedge ref_clk)
		if (posCount > 2000)
		begin
			fail_count = fail_count + 1;
			tally_and_finish();
		end
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic do_reset(input logic mode, input logic sec, input logic bufLow);
		rst = 1'b1;
		modeStrapIn = mode;
		secureLevel = sec;
		bufStrapLow = bufLow;
		note("resetPin", 15'h0008, 15'h0008, 1);
		note_hi("pinsReleased", 6'h3F, 6'h00, 1);
		tick(2);
		rst = 1'b0;
		note("straps", 15'h7000, {mode, bufLow, mode & sec, 12'h000}, 2);
		note_hi("pinsHeld", 6'h03, 6'h00, 1);
		note_hi("pinsDriven", 6'h03, 6'h03, 2);
		tick(2);
	endtask
	task automatic pulse(input int src, input logic emb);
		tick(1);
		{power_good_in, hotResetBit, resetDriveBit} = 3'(4 >> src);
		note("pulseOff", 15'h001C, emb ? 15'h0010 : 15'h0014, 1);
		note("pulseOn", 15'h001C, emb ? 15'h001C : 15'h0014, 2);
		note("pulseEnd", 15'h001C, emb ? 15'h001C : 15'h0014, PULSE + 1);
		note("pulseGone", 15'h001C, emb ? 15'h0010 : 15'h0014, PULSE + 2);
		tick(PULSE + 3);
		{power_good_in, hotResetBit, resetDriveBit} = 3'h0;
	endtask
	task automatic cyc(input logic io, input logic rd, input logic [15:0] a, input logic rom,
		input logic [2:0] hits, input logic [14:0] m, input logic [14:0] e);
		tick(1);
		{cycleActive, cycleIsIo, cycleIsRead, romRangeHit} = {1'b1, io, rd, rom};
		{rtcAddrHit, rtcDataHit, romKbcHit} = hits;
		cycleAddr = a;
		note("decode", m, e, 1);
		note_hi("devSelect", 6'h3F, {e[1] ? 4'h0 : 4'h1 << e[6:5], 2'h3}, 1);
		tick(1);
		{cycleActive, romRangeHit, rtcAddrHit, rtcDataHit, romKbcHit} = 5'h00;
		note("idle", 15'h0063, 15'h0003, 1);
		note_hi("devIdle", 6'h3C, 6'h00, 1);
	endtask
	initial
	begin
		void'($urandom(32'h8704_5b32));
		{fail_count, checks, posCount} = {32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
		{power_good_in, hotResetBit, resetDriveBit, pciResetN} = 4'h1;
		{breakEnable, breakEvents} = {32'h0000_0000, 32'h0000_0000};
		{cycleActive, cycleIsIo, cycleIsRead, romRangeHit} = 4'h0;
		{rtcAddrHit, rtcDataHit, romKbcHit} = 3'h0;
		cycleAddr = 16'h0000;
		do_reset(1'b1, 1'($urandom_range(1)), 1'b0);
		for (int s = 0; s < 3; s++)
			pulse(s, 1'b1);
		cyc(1'b1, 1'b1, 16'h0800, 1'b0, 3'h0, 15'h0FE3, 15'h0140);
		cyc(1'b1, 1'b1, 16'h08FF, 1'b0, 3'h0, 15'h0FE3, 15'h0140);
		cyc(1'b1, 1'b0, 16'h0800 + 16'($urandom_range(255)), 1'b0, 3'h0, 15'h0FE3, 15'h0141);
		cyc(1'b1, 1'b1, 16'h07FF, 1'b0, 3'h0, 15'h0FE2, 15'h0002);
		cyc(1'b1, 1'b1, 16'h0900, 1'b0, 3'h0, 15'h0FE2, 15'h0002);
		cyc(1'b0, 1'b1, 16'h0000, 1'b1, 3'h0, 15'h0FE3, 15'h08A0);
		tick(1);
		pciResetN = 1'b0;
		note("pciReset", 15'h000C, 15'h000C, 1);
		tick(3);
		pciResetN = 1'b1;
		tick(PULSE + 4);
		do_reset(1'b0, 1'b1, 1'b0);
		for (int k = 0; k < 4; k++)
			cyc(1'b1, 1'b1, 16'h0810, 1'b0, 3'(k == 0 ? 0 : 8 >> k), k == 0 ? 15'h0FE2 : 15'h0FE3,
				(15'(k) << 9) | (15'(k) << 5) | (k == 0 ? 15'h0002 : 15'h0000));
		for (int b = 0; b < 4; b++)
		begin
			tick(1);
			breakEnable = 32'h0000_00FF << (8 * b);
			breakEvents = 32'h0000_0001 << (8 * b + $urandom_range(7));
			note("activity", 15'h0014, 15'h0000, 1);
			tick(1);
			breakEvents = ~breakEnable;
			note("masked", 15'h0014, 15'h0014, 1);
		end
		pulse(1, 1'b0);
		do_reset(1'b1, 1'b0, 1'b1);
		tick(4);
		tally_and_finish();
	end
endmodule
`default_nettype wire

// >>> tb/xbmux_xbus_model.sv
// Far-side model: strap resistors on the shared pins and the external device decoder
`default_nettype none
module xbmux_xbus_model
(
	input wire logic xbus_read_n,
	input wire logic xbusReadOe,
	input wire logic xbus_buf_en_n,
	input wire logic xbusBufEnOe,
	input wire logic xbus_sel_lo,
	input wire logic xbus_sel_hi,
	input wire logic secureLevel,
	input wire logic bufStrapLow,
	output logic securePin,
	output logic bufPin,
	output logic [3:0] devSelect
);
	timeunit 1ns;
	timeprecision 1ps;
	// board strap level
	// Released pin settles to the strap resistor, never to the last driven value
	assign securePin = xbusReadOe ? xbus_read_n : secureLevel;
	assign bufPin = xbusBufEnOe ? xbus_buf_en_n : ~bufStrapLow;
	assign devSelect = xbus_buf_en_n ? 4'h0 : 4'h1 << {xbus_sel_hi, xbus_sel_lo};
endmodule
`default_nettype wire
